// [include/rtc_consts.vh]
// constants for the calendar / alarm / tick block
// assumes a 32-bit AHB-Lite slave decoding the low eight address bits
`ifndef RTC_CONSTS_VH
`define RTC_CONSTS_VH

// register byte offsets
`define OFF_CAL_TIME  8'h00
`define OFF_CAL_DATE  8'h04
`define OFF_ALM_TIME  8'h08
`define OFF_ALM_DATE  8'h0C
`define OFF_CTRL      8'h10
`define OFF_BLINK     8'h14
`define OFF_SECS      8'h18
`define OFF_IRQ_STAT  8'h1C
`define OFF_IRQ_MASK  8'h20
`define OFF_STATUS    8'h24

// time word fields (low bit positions)
`define F_SEC         0
`define F_MIN         8
`define F_HOUR        16
// date word fields
`define F_DAY         0
`define F_MON         8
`define F_YEAR        16
// control word bits
`define B_ALARM_ON    0
`define B_TICK_ON     1
`define B_TICK_MIN    2
`define B_MONITOR     3
`define B_BLINK_A     4
`define B_BLINK_B     5
`define F_TRIM        8
// interrupt bits
`define B_EV_ALARM    0
`define B_EV_TICK     1

// timing
`define XTAL_HZ       17'h08000
`define TRIM_WINDOW   4'hF
`define SEC_LAST      6'h3B
`define MIN_LAST      6'h3B
`define HOUR_LAST     5'h17
`define MON_LAST      4'hC
`define YEAR_LAST     6'h3F

// reset values
`define BLINK_PER_RST 32'h40004000
`define CTRL_RST      32'h00000000

`endif

// [logic/rtc_calendar_alarm_tick.v]
// calendar, alarm, tick, trim, seconds counter and blink outputs
// assumes one AHB-Lite master, crystal clock arriving as a plain pin
//
// Function
// RULE_01: count crystal periods into calendar fields
// RULE_02: year zero is 2000, counts to 63
// RULE_03: host reads and writes every calendar field
// RULE_04: calendar clears when core supply lost
// RULE_05: alarm holds minutes through year, no seconds
// RULE_06: alarm match raises irq, wakeup in low power
// RULE_07: alarm trigger sets event register flag
// RULE_08: tick every second or minute as alarm
// RULE_09: source flag tells calendar match from tick
// RULE_10: separate enables for alarm and tick
// RULE_11: clock valid marker cleared on power up
// RULE_12: host sets marker when setting time
// RULE_13: host writes only in-range calendar values
// RULE_14: 32-bit seconds counter cleared by power-on reset
// RULE_15: two blink outputs, running in low power
// RULE_16: rate trim 1/(32768*16) steps, +-127
// RULE_17: trim only internal, clock out untrimmed
// RULE_18: sequencer may disable clock out in low power
// RULE_19: event flag held until host clears it
//
// Design decisions made here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"

module rtc_calendar_alarm_tick #(
  parameter        BLINK_W = 16,
  parameter [16:0] SEC_DIV = `XTAL_HZ  // crystal rises per second
) (
  input  wire        sys_clk,            // 20 MHz system clock
  input  wire        rst_n,              // async reset, active low
  input  wire        hsel,               // slave select
  input  wire [31:0] haddr,              // byte address
  input  wire [1:0]  htrans,             // transfer type
  input  wire        hwrite,             // write when high
  input  wire [2:0]  hsize,              // word only
  input  wire [31:0] hwdata,             // write data
  input  wire        hready,             // bus ready
  output reg         hreadyout,          // slave ready
  output reg         hresp,              // always okay
  output reg  [31:0] hrdata,             // read data
  input  wire        xtal_clk_in,        // 32.768 kHz crystal pin
  input  wire        core_supply,        // high while core is powered
  input  wire        power_on_reset_n,   // power-on reset pin
  input  wire        low_power,          // device in low-power state
  input  wire        seq_clkout_disable, // sequencer clock-out off
  output reg         slow_clock_out,     // untrimmed crystal copy
  output wire        blink_output_a,     // blink pulse a
  output wire        blink_output_b,     // blink pulse b
  output reg         irq,                // level interrupt
  output reg         wakeup              // wakeup request
);

  // days in a month; year 0 (2000) and every fourth year is leap
  function [4:0] month_days;
    input [3:0] m;
    input [5:0] y;
    begin
      case (m)
        4'h2: month_days = (y[1:0] == 2'h0) ? 5'h1D : 5'h1C;
        4'h4, 4'h6, 4'h9, 4'hB: month_days = 5'h1E;
        default: month_days = 5'h1F;
      endcase
    end
  endfunction

  // pin synchronisers: first stage read only by the second
  reg  [4:0]  sync1_q;
  reg  [4:0]  sync2_q;
  reg         xtal_prev_q;
  wire        xtal_s   = sync2_q[0];
  wire        core_ok  = sync2_q[1];
  wire        por_ok   = sync2_q[2];
  wire        lp_s     = sync2_q[3];
  wire        seq_dis  = sync2_q[4];
  wire        xrise    = xtal_s & ~xtal_prev_q;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q     <= 5'h00;
      sync2_q     <= 5'h00;
      xtal_prev_q <= 1'b0;
    end else begin
      sync1_q     <= {seq_clkout_disable, low_power,
                      power_on_reset_n, core_supply, xtal_clk_in};
      sync2_q     <= sync1_q;
      xtal_prev_q <= xtal_s;
    end
  end

  // bus state
  reg  [7:0]  addr_q;
  reg         wr_q;
  reg         pend_q;
  wire        take  = hsel & htrans[1] & hready;
  wire        wr_en = pend_q & wr_q;
  wire        rd_done = ~hreadyout;

  // software-visible registers
  reg  [5:0]  sec_q;
  reg  [5:0]  min_q;
  reg  [4:0]  hour_q;
  reg  [4:0]  day_q;
  reg  [3:0]  mon_q;
  reg  [5:0]  year_q;
  reg  [5:0]  a_min_q;
  reg  [4:0]  a_hour_q;
  reg  [4:0]  a_day_q;
  reg  [3:0]  a_mon_q;
  reg  [5:0]  a_year_q;
  reg  [31:0] ctrl_q;
  reg  [31:0] blink_per_q;
  reg  [31:0] secs_q;
  reg  [1:0]  stat_q;
  reg  [1:0]  mask_q;
  reg         alarm_type_q;

  // time base
  reg  [16:0] pre_q;
  reg  [3:0]  win_q;
  reg         match_prev_q;
  reg  [BLINK_W-1:0] bcnt_q [0:1];
  reg  [1:0]  blink_q;

  wire        alarm_on = ctrl_q[`B_ALARM_ON];
  wire        tick_on  = ctrl_q[`B_TICK_ON];
  wire        tick_min = ctrl_q[`B_TICK_MIN];
  wire [7:0]  trim     = ctrl_q[`F_TRIM +: 8];

  // trim applied once per 16-second window, 1/(32768*16) per step
  wire [16:0] period = (win_q == 4'h0) ?
                       (SEC_DIV - {{9{trim[7]}}, trim}) : SEC_DIV;
  wire        sec_tick = core_ok & xrise &                 // [RULE_16]
                         (pre_q >= period - 17'h00001);

  // alarm compare needs calendar seconds at zero; fires when the match begins
  wire        match = (min_q == a_min_q) && (hour_q == a_hour_q) &&
                      (day_q == a_day_q) && (mon_q == a_mon_q) &&
                      (year_q == a_year_q) && (sec_q == 6'h00);
  wire        alarm_evt = core_ok & alarm_on &             // [RULE_10]
                          match & ~match_prev_q;           // [RULE_05]
  wire        tick_evt  = tick_on & sec_tick &             // [RULE_08]
                          (~tick_min | (sec_q == `SEC_LAST));

  // status bits read by the bus in the wait cycle
  wire [1:0]  stat_clr = (rd_done && addr_q == `OFF_IRQ_STAT) ?
                         stat_q : 2'h0;
  wire [1:0]  stat_d   = (stat_q & ~stat_clr) |            // [RULE_19]
                         {tick_evt, alarm_evt};

  // read multiplexer
  reg  [31:0] rdata;
  always @* begin
    rdata = 32'h00000000;
    case (addr_q)
      `OFF_CAL_TIME: begin                                 // [RULE_03]
        rdata[`F_SEC  +: 6] = sec_q;
        rdata[`F_MIN  +: 6] = min_q;
        rdata[`F_HOUR +: 5] = hour_q;
      end
      `OFF_CAL_DATE: begin
        rdata[`F_DAY  +: 5] = day_q;
        rdata[`F_MON  +: 4] = mon_q;
        rdata[`F_YEAR +: 6] = year_q;
      end
      `OFF_ALM_TIME: begin
        rdata[`F_MIN  +: 6] = a_min_q;
        rdata[`F_HOUR +: 5] = a_hour_q;
      end
      `OFF_ALM_DATE: begin
        rdata[`F_DAY  +: 5] = a_day_q;
        rdata[`F_MON  +: 4] = a_mon_q;
        rdata[`F_YEAR +: 6] = a_year_q;
      end
      `OFF_CTRL:     rdata = ctrl_q;
      `OFF_BLINK:    rdata = blink_per_q;
      `OFF_SECS:     rdata = secs_q;
      `OFF_IRQ_STAT: rdata[1:0] = stat_q;
      `OFF_IRQ_MASK: rdata[1:0] = mask_q;
      `OFF_STATUS:   rdata[1:0] = {core_ok, alarm_type_q}; // [RULE_09]
      default:       rdata = 32'h00000000;
    endcase
  end

  // ahb-lite slave: writes zero wait, reads one wait state so that
  // a read right behind a write sees the written value
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q    <= 8'h00;
      wr_q      <= 1'b0;
      pend_q    <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h00000000;
    end else begin
      pend_q <= take;
      hresp  <= 1'b0;
      if (take) begin
        addr_q <= haddr[7:0];
        wr_q   <= hwrite;
      end
      if (take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (rd_done) begin
        hreadyout <= 1'b1;
        hrdata    <= rdata;
      end
    end
  end

  // control, alarm and blink registers
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= `CTRL_RST;
      blink_per_q <= `BLINK_PER_RST;
      mask_q      <= 2'h0;
      a_min_q     <= 6'h00;
      a_hour_q    <= 5'h00;
      a_day_q     <= 5'h00;
      a_mon_q     <= 4'h0;
      a_year_q    <= 6'h00;
    end else begin
      if (wr_en && addr_q == `OFF_CTRL) begin
        ctrl_q <= {16'h0000, hwdata[15:8], 2'h0, hwdata[5:0]};
      end
      // the marker falls whenever the core rail drops
      if (!core_ok) begin
        ctrl_q[`B_MONITOR] <= 1'b0;                        // [RULE_11]
      end
      if (wr_en && addr_q == `OFF_BLINK) begin
        blink_per_q <= hwdata;
      end
      if (wr_en && addr_q == `OFF_IRQ_MASK) begin
        mask_q <= hwdata[1:0];
      end
      if (wr_en && addr_q == `OFF_ALM_TIME) begin          // [RULE_05]
        a_min_q  <= hwdata[`F_MIN  +: 6];
        a_hour_q <= hwdata[`F_HOUR +: 5];
      end
      if (wr_en && addr_q == `OFF_ALM_DATE) begin
        a_day_q  <= hwdata[`F_DAY  +: 5];
        a_mon_q  <= hwdata[`F_MON  +: 4];
        a_year_q <= hwdata[`F_YEAR +: 6];
      end
    end
  end

  // prescaler: counts crystal edges, window counter for the trim
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 17'h00000;
      win_q <= 4'h0;
    end else if (!core_ok) begin
      pre_q <= 17'h00000;
      win_q <= 4'h0;
    end else if (sec_tick) begin                           // [RULE_01]
      pre_q <= 17'h00000;
      win_q <= (win_q == `TRIM_WINDOW) ? 4'h0 : win_q + 4'h1;
    end else if (xrise) begin
      pre_q <= pre_q + 17'h00001;
    end
  end

  // calendar: supply loss beats bus write beats advance
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_q  <= 6'h00;
      min_q  <= 6'h00;
      hour_q <= 5'h00;
      day_q  <= 5'h00;
      mon_q  <= 4'h0;
      year_q <= 6'h00;
    end else if (!core_ok) begin                           // [RULE_04]
      sec_q  <= 6'h00;
      min_q  <= 6'h00;
      hour_q <= 5'h00;
      day_q  <= 5'h00;
      mon_q  <= 4'h0;
      year_q <= 6'h00;
    end else if (wr_en && addr_q == `OFF_CAL_TIME) begin   // [RULE_03]
      // out-of-range values are taken as written
      sec_q  <= hwdata[`F_SEC  +: 6];                      // [RULE_13]
      min_q  <= hwdata[`F_MIN  +: 6];
      hour_q <= hwdata[`F_HOUR +: 5];
    end else if (wr_en && addr_q == `OFF_CAL_DATE) begin
      day_q  <= hwdata[`F_DAY  +: 5];
      mon_q  <= hwdata[`F_MON  +: 4];
      year_q <= hwdata[`F_YEAR +: 6];
    end else if (sec_tick) begin                           // [RULE_01]
      if (sec_q < `SEC_LAST) begin
        sec_q <= sec_q + 6'h01;
      end else begin
        sec_q <= 6'h00;
        if (min_q < `MIN_LAST) begin
          min_q <= min_q + 6'h01;
        end else begin
          min_q <= 6'h00;
          if (hour_q < `HOUR_LAST) begin
            hour_q <= hour_q + 5'h01;
          end else begin
            hour_q <= 5'h00;
            if (day_q < month_days(mon_q, year_q)) begin
              day_q <= day_q + 5'h01;
            end else begin
              day_q <= 5'h01;
              if (mon_q < `MON_LAST) begin
                mon_q <= mon_q + 4'h1;
              end else begin
                mon_q <= 4'h1;
                // wraps back to 2000 after 63
                year_q <= (year_q == `YEAR_LAST) ?         // [RULE_02]
                          6'h00 : year_q + 6'h01;
              end
            end
          end
        end
      end
    end
  end

  // free seconds counter, not cleared by the calendar rail but stopped while it is down
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      secs_q <= 32'h00000000;
    end else if (!por_ok) begin                            // [RULE_14]
      secs_q <= 32'h00000000;
    end else if (sec_tick) begin
      secs_q <= secs_q + 32'h00000001;
    end
  end

  // events, interrupt and wakeup
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_q       <= 2'h0;
      match_prev_q <= 1'b0;
      alarm_type_q <= 1'b0;
      irq          <= 1'b0;
      wakeup       <= 1'b0;
    end else begin
      match_prev_q <= match;
      stat_q       <= stat_d;                              // [RULE_07]
      // registered irq is set from stat_d, so it changes in the same cycle as the flag
      irq          <= |(stat_d & mask_q);                  // [RULE_06]
      if (alarm_evt) begin
        alarm_type_q <= 1'b0;                              // [RULE_09]
      end else if (tick_evt) begin
        alarm_type_q <= 1'b1;
      end
      if (!lp_s) begin
        wakeup <= 1'b0;
      end else if (alarm_evt || tick_evt) begin
        wakeup <= 1'b1;                                    // [RULE_06]
      end
    end
  end

  // blink dividers: not gated by low power on purpose
  integer i;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bcnt_q[0] <= {BLINK_W{1'b0}};
      bcnt_q[1] <= {BLINK_W{1'b0}};
      blink_q   <= 2'h0;
    end else if (xrise) begin
      for (i = 0; i < 2; i = i + 1) begin
        if (!ctrl_q[`B_BLINK_A + i]) begin
          bcnt_q[i]  <= {BLINK_W{1'b0}};
          blink_q[i] <= 1'b0;
        end else if (bcnt_q[i] >= blink_per_q[i*16 +: BLINK_W]) begin
          bcnt_q[i]  <= {BLINK_W{1'b0}};
          blink_q[i] <= ~blink_q[i];                       // [RULE_15]
        end else begin
          bcnt_q[i]  <= bcnt_q[i] + {{(BLINK_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  assign blink_output_a = blink_q[0];
  assign blink_output_b = blink_q[1];

  // clock out from the raw crystal, never the trimmed count
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slow_clock_out <= 1'b0;
    end else begin
      slow_clock_out <= xtal_s & ~(lp_s & seq_dis);      // [RULE_17] [RULE_18]
    end
  end

endmodule

`default_nettype wire

// [verification/rtc_calendar_alarm_tick_monitor.sv]
// checker for bus handshake and pin relations of the rtc block
// assumes it is bound to the top module, one clock domain
`timescale 1ns/1ns
`default_nettype none
module rtc_monitor #(
  parameter BLINK_W = 16
) (
  input wire logic        sys_clk,            // clock
  input wire logic        rst_n,              // reset
  input wire logic        hsel,               // select
  input wire logic [31:0] haddr,              // address
  input wire logic [1:0]  htrans,             // type
  input wire logic        hwrite,             // write
  input wire logic [2:0]  hsize,              // size
  input wire logic [31:0] hwdata,             // wdata
  input wire logic        hready,             // ready in
  input wire logic        hreadyout,          // ready out
  input wire logic        hresp,              // response
  input wire logic [31:0] hrdata,             // rdata
  input wire logic        xtal_clk_in,        // crystal
  input wire logic        core_supply,        // core rail
  input wire logic        power_on_reset_n,   // por
  input wire logic        low_power,          // low power
  input wire logic        seq_clkout_disable, // clock out off
  input wire logic        slow_clock_out,     // clock out
  input wire logic        blink_output_a,     // blink a
  input wire logic        blink_output_b,     // blink b
  input wire logic        irq,                // interrupt
  input wire logic        wakeup              // wakeup
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // bus answers: never an error, one wait per read, none per write
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  read_wait_a: assert property (
    (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_ready_a: assert property (
    (hsel && htrans[1] && hready && hwrite) |=> hreadyout)
    else $error("write stalled");
  rdata_hold_a: assert property (
    $changed(hrdata) |-> !$past(hreadyout))
    else $error("hrdata moved outside read");
  // wakeup only in low power; two-flop sync leaves a few cycles slack
  wake_clear_a: assert property (!low_power [*5] |-> !wakeup)
    else $error("wakeup outside low power");
  wake_cause_a: assert property ($rose(wakeup) |->
    ($past(low_power, 2) || $past(low_power, 3) || $past(low_power, 4)))
    else $error("wakeup rose without low power");
  clkout_off_a: assert property (
    (low_power && seq_clkout_disable) [*5] |-> !slow_clock_out)
    else $error("clock out not disabled");
  clkout_edge_a: assert property ($rose(slow_clock_out) |->
    ($past(xtal_clk_in, 2) || $past(xtal_clk_in, 3) ||
     $past(xtal_clk_in, 4)))
    else $error("clock out edge without crystal");
endmodule
`default_nettype wire

// [verification/tb.sv]
// self-checking bench for the rtc block over its bus and pins
// assumes rtc_consts.vh on the include path, bus master is this bench
`timescale 1ns/1ns
`default_nettype none
`include "rtc_consts.vh"
module tb;
  localparam XH = 4; // crystal half period in sys_clk cycles
  logic        sys_clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
  logic        xtal_clk_in = 0, core_supply = 1, power_on_reset_n = 0;
  logic        low_power = 0, seq_clkout_disable = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire         hreadyout, hresp, slow_clock_out, irq, wakeup;
  wire         blink_output_a, blink_output_b;
  wire  [31:0] hrdata;
  integer      miscompares = 0, checks_done = 0, xc = 0, n, i;
  logic [72:0] rows [10];

  // short second so that ticks, trim and counting fit in the run
  rtc_calendar_alarm_tick #(.BLINK_W(16), .SEC_DIV(17'h000C8))
    i_dut (.sys_clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .xtal_clk_in, .core_supply,
    .power_on_reset_n, .low_power, .seq_clkout_disable, .slow_clock_out,
    .blink_output_a, .blink_output_b, .irq, .wakeup);

  // clock and a fast crystal, far slower than sys_clk/3
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    xc <= (xc == XH - 1) ? 0 : xc + 1;
    if (xc == XH - 1) xtal_clk_in <= ~xtal_clk_in;
  end

  task final_report;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    begin
      checks_done++;
      if (seen !== e) begin
        miscompares++;
        $display("mismatch %s expected %h seen %h", nm, e, seen);
      end
    end
  endtask
  task tmo(input logic hit);
    if (hit) begin
      miscompares++;
      final_report;
    end
  endtask
  // one single transfer; address phase held until hready, then data phase
  task xfer(input [7:0] a, input logic w, input [31:0] d);
    integer k;
    begin
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      k = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && k < 60) begin
        k++;
        @(posedge sys_clk);
      end
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && k < 60) begin
        k++;
        @(posedge sys_clk);
      end
      q = hrdata;
      tmo(k >= 60);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h00000000);
      chk("register", q, e);
    end
  endtask
  task wait_irq(input logic v, input integer lim);
    integer k;
    begin
      k = 0;
      while (irq !== v && k < lim) begin
        k++;
        @(posedge sys_clk);
      end
      tmo(k >= lim);
    end
  endtask
  // cycles between two successive toggles of one blink output
  task blink_per(input logic b, output integer m);
    logic s;
    integer k;
    begin
      k = 0;
      m = 0;
      s = b ? blink_output_b : blink_output_a;
      while ((b ? blink_output_b : blink_output_a) === s && k < 300) begin
        k++;
        @(posedge sys_clk);
      end
      s = b ? blink_output_b : blink_output_a;
      while ((b ? blink_output_b : blink_output_a) === s && m < 300) begin
        m++;
        @(posedge sys_clk);
      end
    end
  endtask

  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    final_report;
  end

  initial begin
    rows = '{{`OFF_CTRL, 1'b0, 32'h0, `CTRL_RST},
      {`OFF_BLINK, 1'b0, 32'h0, `BLINK_PER_RST},
      {`OFF_IRQ_MASK, 1'b0, 32'h0, 32'h0},
      {`OFF_CAL_TIME, 1'b0, 32'h0, 32'h0},
      {`OFF_CAL_TIME, 1'b1, 32'hFF173B3A, 32'h00173B3A},
      {`OFF_CAL_DATE, 1'b1, 32'hFF3F0C1F, 32'h003F0C1F},
      {`OFF_ALM_TIME, 1'b1, 32'hFF173BFF, 32'h00173B00},
      {`OFF_ALM_DATE, 1'b1, 32'h00150C1F, 32'h00150C1F},
      {`OFF_SECS, 1'b1, 32'hFFFFFFFF, 32'h0},
      {8'h40, 1'b1, 32'hFFFFFFFF, 32'h0}};
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    // register table: reset values, field widths, read-only, unmapped
    for (i = 0; i < 10; i++) begin
      if (rows[i][64]) wr(rows[i][72:65], rows[i][63:32]);
      rdc(rows[i][72:65], rows[i][31:0]);
    end
    power_on_reset_n <= 1'b1;
    $display("test table done");
    // core supply loss clears calendar and the valid marker
    wr(`OFF_CTRL, 32'h00000008);
    wr(`OFF_CAL_TIME, 32'h00010203);
    core_supply <= 1'b0;
    repeat (8) @(posedge sys_clk);
    core_supply <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rdc(`OFF_CAL_TIME, 32'h0);
    rdc(`OFF_CAL_DATE, 32'h0);
    rdc(`OFF_CTRL, 32'h0);
    $display("test supply done");
    // alarm match created by a write, in low power
    low_power <= 1'b1;
    wr(`OFF_ALM_TIME, 32'h00030500);
    wr(`OFF_ALM_DATE, 32'h00020304);
    wr(`OFF_CAL_DATE, 32'h00020304);
    wr(`OFF_IRQ_MASK, 32'h00000001);
    wr(`OFF_CTRL, 32'h00000001);
    wr(`OFF_CAL_TIME, 32'h00030500);
    wait_irq(1'b1, 60);
    chk("wakeup", wakeup, 1'b1);
    rdc(`OFF_STATUS, 32'h00000002);
    rdc(`OFF_IRQ_STAT, 32'h00000001);
    wait_irq(1'b0, 60);
    rdc(`OFF_IRQ_STAT, 32'h0);
    // masked retrigger sets the flag again, unmask raises irq
    wr(`OFF_IRQ_MASK, 32'h0);
    wr(`OFF_CAL_TIME, 32'h00030600);
    wr(`OFF_CAL_TIME, 32'h00030500);
    repeat (10) @(posedge sys_clk);
    chk("irq", irq, 1'b0);
    wr(`OFF_IRQ_MASK, 32'h00000001);
    wait_irq(1'b1, 60);
    rdc(`OFF_IRQ_STAT, 32'h00000001);
    // alarm disabled: a match leaves no event
    wr(`OFF_CTRL, 32'h0);
    wr(`OFF_CAL_TIME, 32'h00030600);
    wr(`OFF_CAL_TIME, 32'h00030500);
    repeat (10) @(posedge sys_clk);
    rdc(`OFF_IRQ_STAT, 32'h0);
    low_power <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("wakeup", wakeup, 1'b0);
    $display("test alarm done");
    // clock out gated by the sequencer in low power, running again once released
    low_power <= 1'b1;
    seq_clkout_disable <= 1'b1;
    repeat (6) @(posedge sys_clk);
    n = 0;
    repeat (40) @(posedge sys_clk) if (slow_clock_out !== 1'b0) n++;
    chk("clock out off", n, 0);
    seq_clkout_disable <= 1'b0;
    repeat (6) @(posedge sys_clk);
    n = 0;
    repeat (40) @(posedge sys_clk) if (slow_clock_out === 1'b1) n++;
    chk("clock out runs", n > 0, 1);
    // blink in low power with maximum trim, trim must not touch the blink periods
    wr(`OFF_BLINK, 32'h00010003);
    wr(`OFF_CTRL, 32'h00007F30);
    blink_per(1'b0, n);
    chk("blink a", n, 2 * XH * (3 + 1));
    blink_per(1'b1, n);
    chk("blink b", n, 2 * XH * (1 + 1));
    wr(`OFF_CTRL, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk("blink off", {blink_output_a, blink_output_b}, 2'h0);
    $display("test blink done");
    // tick: first second after a rail drop is the trimmed one
    wr(`OFF_IRQ_MASK, 32'h00000002);
    wr(`OFF_CTRL, 32'h00007F02);
    core_supply <= 1'b0;
    power_on_reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    core_supply <= 1'b1;
    power_on_reset_n <= 1'b1;
    wait_irq(1'b1, 700);
    rdc(`OFF_STATUS, 32'h00000003);
    rdc(`OFF_IRQ_STAT, 32'h00000002);
    rdc(`OFF_CAL_TIME, 32'h00000001);
    rdc(`OFF_SECS, 32'h00000001);
    // minute tick: none at second 59, one at the rollover
    wr(`OFF_CAL_TIME, 32'h00000A3A);
    wr(`OFF_CTRL, 32'h00000006);
    wait_irq(1'b1, 4000);
    rdc(`OFF_CAL_TIME, 32'h00000B00);
    rdc(`OFF_IRQ_STAT, 32'h00000002);
    wr(`OFF_CTRL, 32'h0);
    $display("test tick done");
    // second reset in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("hreadyout", hreadyout, 1'b1);
    chk("irq", irq, 1'b0);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(`OFF_BLINK, `BLINK_PER_RST);
    $display("test reset done");
    final_report;
  end
endmodule

bind rtc_calendar_alarm_tick rtc_monitor #(.BLINK_W(BLINK_W)) i_mon (
  .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
  .hready, .hreadyout, .hresp, .hrdata, .xtal_clk_in, .core_supply,
  .power_on_reset_n, .low_power, .seq_clkout_disable, .slow_clock_out,
  .blink_output_a, .blink_output_b, .irq, .wakeup);
`default_nettype wire
